// File: logic/codec_ctrl_pkg.sv
// constants for the codec control register bank: serial subaddresses,
// register numbers, storage indices and field positions.
// assumes the register bank module and its bench are the only users.
`default_nettype none
package codec_ctrl_pkg;
   // device address: low bit comes from the address select strap
   localparam logic [6:0] DEV_ADDR_BASE = 7'h1e;
   localparam logic [7:0] SUB_WRITE = 8'h6c;
   localparam logic [7:0] SUB_READ = 8'h6d;
   localparam logic [15:0] REG_RESET = 16'h0000;
   localparam logic [3:0] BYTE_BITS = 4'h8;
   // byte numbers within one transfer, address byte is 0
   localparam logic [2:0] BY_SUB = 3'h1;
   localparam logic [2:0] BY_RHI = 3'h2;
   localparam logic [2:0] BY_RLO = 3'h3;
   localparam logic [2:0] BY_DHI = 3'h4;
   localparam logic [2:0] BY_DLO = 3'h5;
   // register numbers
   localparam logic [15:0] A_CONV = 16'h0000;
   localparam logic [15:0] A_MIX_ADC = 16'h0006;
   localparam logic [15:0] A_MIX_DSP = 16'h0007;
   localparam logic [15:0] A_LVL_INL = 16'h000a;
   localparam logic [15:0] A_LVL_INR = 16'h000b;
   localparam logic [15:0] A_LVL_PRL = 16'h000c;
   localparam logic [15:0] A_LVL_PRR = 16'h000d;
   localparam logic [15:0] A_OUT_MODE = 16'h000e;
   localparam logic [15:0] A_OUT_SRC = 16'h000f;
   localparam logic [15:0] A_MAIN = 16'h0010;
   localparam logic [15:0] A_TRIM = 16'h0011;
   localparam logic [15:0] A_AUTO = 16'h0012;
   localparam logic [15:0] A_LOW = 16'h0014;
   localparam logic [15:0] A_HIGH = 16'h0015;
   localparam logic [15:0] A_CONTOUR = 16'h001e;
   localparam logic [15:0] A_SHAPE = 16'h0021;
   localparam logic [15:0] A_STRENGTH = 16'h0022;
   localparam logic [15:0] A_HARM = 16'h0023;
   localparam logic [15:0] A_CENTRE = 16'h0024;
   localparam logic [15:0] A_IN_MODE = 16'h8000;
   // storage indices of the writable registers
   localparam logic [3:0] I_CONV = 4'h0;
   localparam logic [3:0] I_MIX_ADC = 4'h1;
   localparam logic [3:0] I_MIX_DSP = 4'h2;
   localparam logic [3:0] I_OUT_MODE = 4'h3;
   localparam logic [3:0] I_OUT_SRC = 4'h4;
   localparam logic [3:0] I_MAIN = 4'h5;
   localparam logic [3:0] I_TRIM = 4'h6;
   localparam logic [3:0] I_AUTO = 4'h7;
   localparam logic [3:0] I_LOW = 4'h8;
   localparam logic [3:0] I_HIGH = 4'h9;
   localparam logic [3:0] I_CONTOUR = 4'ha;
   localparam logic [3:0] I_SHAPE = 4'hb;
   localparam logic [3:0] I_STRENGTH = 4'hc;
   localparam logic [3:0] I_HARM = 4'hd;
   localparam logic [3:0] I_CENTRE = 4'he;
   localparam logic [3:0] I_IN_MODE = 4'hf;
   // field positions
   localparam int F_HI = 8;
   localparam int F_GAIN_L = 12;
   localparam int F_GAIN_R = 8;
   localparam int F_MIC = 4;
   localparam int F_LSEL = 3;
   localparam int F_EN_L = 2;
   localparam int F_EN_R = 1;
   localparam int F_EN_DA = 0;
   localparam int F_TOP = 15;
   localparam int F_INV = 14;
   localparam int F_DEEMPH = 0;
   localparam int F_BASS_ON = 1;
   localparam int F_AUTO_ON = 12;
   localparam int F_DECAY = 8;

   // bit 4 flags a writable register, low bits give its storage index
   function automatic logic [4:0] reg_index(input logic [15:0] a);
      case (a)
         A_CONV: reg_index = {1'b1, I_CONV};
         A_MIX_ADC: reg_index = {1'b1, I_MIX_ADC};
         A_MIX_DSP: reg_index = {1'b1, I_MIX_DSP};
         A_OUT_MODE: reg_index = {1'b1, I_OUT_MODE};
         A_OUT_SRC: reg_index = {1'b1, I_OUT_SRC};
         A_MAIN: reg_index = {1'b1, I_MAIN};
         A_TRIM: reg_index = {1'b1, I_TRIM};
         A_AUTO: reg_index = {1'b1, I_AUTO};
         A_LOW: reg_index = {1'b1, I_LOW};
         A_HIGH: reg_index = {1'b1, I_HIGH};
         A_CONTOUR: reg_index = {1'b1, I_CONTOUR};
         A_SHAPE: reg_index = {1'b1, I_SHAPE};
         A_STRENGTH: reg_index = {1'b1, I_STRENGTH};
         A_HARM: reg_index = {1'b1, I_HARM};
         A_CENTRE: reg_index = {1'b1, I_CENTRE};
         A_IN_MODE: reg_index = {1'b1, I_IN_MODE};
         default: reg_index = 5'h00;
      endcase
   endfunction
endpackage
`default_nettype wire

// File: logic/codec_ctrl_regs.sv
// codec control and status registers behind a two-wire serial slave.
// assumes a single host master, scl well below mclk/8, no clock stretch.
//
// Operation
// - read: set number, restart, two bytes, nack
// - write: number then data, high byte first
// - 16-bit registers only via two subaddresses
// - microphone gain from 4-bit field
// - left input select line or microphone
// - converter enables; dac bit drives reference
// - mono bit copies left into right
// - two-bit de-emphasis select
// - dac source core or a/d
// - 8-bit linear mixer scale factors
// - mono matrix and right invert bits
// - signed bass and treble gain bytes
// - contour gain upper byte
// - bass effect strength byte
// - bass effect harmonics byte
// - bass effect centre in 10 Hz
// - bass effect corner in 10 Hz
// - shape bit 1 turns effect on
// - auto level on/off and decay nibble
// - signed balance byte
// - main volume byte, zero mutes at reset
// - level registers return 15-bit value
`default_nettype none
module codec_ctrl_regs (
   // clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // serial pins, open drain
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   input wire logic addr_select,
   // levels from the signal path
   input wire logic [14:0] input_level_left,
   input wire logic [14:0] input_level_right,
   input wire logic [14:0] processing_level_left,
   input wire logic [14:0] processing_level_right,
   // converter setup
   output logic [3:0] adc_gain_left,
   output logic [3:0] adc_gain_right,
   output logic [3:0] mic_gain,
   output logic left_src_mic,
   output logic adc_left_en,
   output logic adc_right_en,
   output logic dac_en,
   output logic analog_reference_en,
   output logic input_mono,
   output logic [1:0] deemph_sel,
   // output path
   output logic dac_src_adc,
   output logic [7:0] mix_adc_scale,
   output logic [7:0] mix_dsp_scale,
   output logic out_mono,
   output logic out_invert_right,
   // tone and level
   output logic [7:0] low_shelf_gain,
   output logic [7:0] high_shelf_gain,
   output logic [7:0] contour_gain,
   output logic [7:0] contour_fine,
   output logic [7:0] bass_effect_strength,
   output logic [7:0] bass_effect_harmonics,
   output logic [7:0] bass_effect_centre,
   output logic [7:0] bass_effect_corner,
   output logic bass_effect_on,
   output logic auto_level_on,
   output logic [3:0] auto_level_decay,
   output logic [7:0] left_right_trim,
   output logic [7:0] main_gain
);
   typedef enum logic [2:0] {st_idle, st_rx, st_ack, st_tx, st_rack}
      state_t;

   state_t state_q;
   logic scl_s1, scl_s2, scl_s3, sda_s1, sda_s2, sda_s3;
   logic sel_s1, sel_s2;
   logic scl_rise, scl_fall, start_c, stop_c;
   logic [3:0] nbits_q;
   logic [2:0] byte_q;
   logic [7:0] sh_q, rhi_q, dhi_q, dlo_q;
   logic rw_q, sub_wr_q, rd_lo_q, sda_oe_q;
   logic [15:0] ptr_q, word_q, rd_word;
   logic [15:0] mem_q [16];
   logic byte_ok, wr_go;
   logic [4:0] widx;

   // edge detect looks only at second and third stages
   always_ff @(posedge mclk or negedge resetn)
      if (!resetn)
      begin
         {scl_s1, scl_s2, scl_s3} <= 3'h7;
         {sda_s1, sda_s2, sda_s3} <= 3'h7;
         {sel_s1, sel_s2} <= 2'h0;
      end
      else
      begin
         {scl_s1, scl_s2, scl_s3} <= {scl_i, scl_s1, scl_s2};
         {sda_s1, sda_s2, sda_s3} <= {sda_i, sda_s1, sda_s2};
         {sel_s1, sel_s2} <= {addr_select, sel_s1};
      end

   assign scl_rise = scl_s2 & ~scl_s3;
   assign scl_fall = ~scl_s2 & scl_s3;
   assign start_c = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
   assign stop_c = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;

   // accept or refuse the byte just shifted in
   always_comb
   begin
      byte_ok = 1'b0;
      case (byte_q)
         3'h0: byte_ok = sh_q[7:1] ==
            {codec_ctrl_pkg::DEV_ADDR_BASE[6:1], sel_s2};
         codec_ctrl_pkg::BY_SUB:
            byte_ok = (sh_q == codec_ctrl_pkg::SUB_WRITE) ||
                      (sh_q == codec_ctrl_pkg::SUB_READ);
         codec_ctrl_pkg::BY_RHI, codec_ctrl_pkg::BY_RLO,
         codec_ctrl_pkg::BY_DHI, codec_ctrl_pkg::BY_DLO:
            byte_ok = sub_wr_q;
         default: byte_ok = 1'b0;
      endcase
   end

   assign widx = codec_ctrl_pkg::reg_index(ptr_q);
   // commit on the falling edge that closes the last data ack
   assign wr_go = (state_q == st_ack) && scl_fall && widx[4] &&
                  (byte_q == codec_ctrl_pkg::BY_DLO);

   // read data: level registers carry a zero top bit
   always_comb
   begin
      rd_word = 16'h0000;
      case (ptr_q)
         codec_ctrl_pkg::A_LVL_INL: rd_word = {1'b0, input_level_left};
         codec_ctrl_pkg::A_LVL_INR: rd_word = {1'b0, input_level_right};
         codec_ctrl_pkg::A_LVL_PRL:
            rd_word = {1'b0, processing_level_left};
         codec_ctrl_pkg::A_LVL_PRR:
            rd_word = {1'b0, processing_level_right};
         default: rd_word = widx[4] ? mem_q[widx[3:0]] : 16'h0000;
      endcase
   end

   // serial slave sequencer
   always_ff @(posedge mclk or negedge resetn)
      if (!resetn)
      begin
         state_q <= st_idle;
         nbits_q <= 4'h0;
         byte_q <= 3'h0;
         sh_q <= 8'h00;
         rhi_q <= 8'h00;
         dhi_q <= 8'h00;
         dlo_q <= 8'h00;
         rw_q <= 1'b0;
         sub_wr_q <= 1'b0;
         rd_lo_q <= 1'b0;
         ptr_q <= 16'h0000;
         word_q <= 16'h0000;
         sda_oe_q <= 1'b0;
      end
      else if (start_c)
      begin
         // a restart keeps the register number for the read
         state_q <= st_rx;
         nbits_q <= 4'h0;
         byte_q <= 3'h0;
         sda_oe_q <= 1'b0;
      end
      else if (stop_c)
      begin
         state_q <= st_idle;
         sda_oe_q <= 1'b0;
      end
      else
         case (state_q)
            st_rx:
               if (scl_rise)
               begin
                  sh_q <= {sh_q[6:0], sda_s2};
                  nbits_q <= nbits_q + 4'h1;
               end
               else if (scl_fall && nbits_q == codec_ctrl_pkg::BYTE_BITS)
               begin
                  nbits_q <= 4'h0;
                  if (byte_ok)
                  begin
                     state_q <= st_ack;
                     sda_oe_q <= 1'b1;
                     case (byte_q)
                        3'h0: rw_q <= sh_q[0];
                        codec_ctrl_pkg::BY_SUB:
                           sub_wr_q <= sh_q == codec_ctrl_pkg::SUB_WRITE;
                        codec_ctrl_pkg::BY_RHI: rhi_q <= sh_q;
                        codec_ctrl_pkg::BY_RLO: ptr_q <= {rhi_q, sh_q};
                        codec_ctrl_pkg::BY_DHI: dhi_q <= sh_q;
                        default: dlo_q <= sh_q;
                     endcase
                  end
                  else
                     state_q <= st_idle;
               end
            st_ack:
               if (scl_fall)
               begin
                  byte_q <= byte_q + 3'h1;
                  nbits_q <= 4'h0;
                  if (rw_q && byte_q == 3'h0)
                  begin
                     // read: high byte first, then low byte
                     state_q <= st_tx;
                     word_q <= rd_word;
                     sh_q <= rd_word[15:8];
                     sda_oe_q <= ~rd_word[15];
                     rd_lo_q <= 1'b0;
                  end
                  else
                  begin
                     state_q <= st_rx;
                     sda_oe_q <= 1'b0;
                  end
               end
            st_tx:
               if (scl_rise)
                  nbits_q <= nbits_q + 4'h1;
               else if (scl_fall)
               begin
                  if (nbits_q == codec_ctrl_pkg::BYTE_BITS)
                  begin
                     state_q <= st_rack;
                     sda_oe_q <= 1'b0;
                  end
                  else
                  begin
                     sh_q <= {sh_q[6:0], 1'b0};
                     sda_oe_q <= ~sh_q[6];
                  end
               end
            st_rack:
               if (scl_rise && sda_s2)
                  state_q <= st_idle;
               else if (scl_fall)
               begin
                  // bytes past the second byte read as zero
                  state_q <= st_tx;
                  nbits_q <= 4'h0;
                  rd_lo_q <= 1'b1;
                  sh_q <= rd_lo_q ? 8'h00 : word_q[7:0];
                  sda_oe_q <= rd_lo_q ? 1'b1 : ~word_q[7];
               end
            default:
               sda_oe_q <= 1'b0;
         endcase

   // register storage, written only by a completed write
   always_ff @(posedge mclk or negedge resetn)
      if (!resetn)
      begin
         for (int i = 0; i < 16; i++)
            mem_q[i] <= codec_ctrl_pkg::REG_RESET;
      end
      else if (wr_go && sub_wr_q)
         mem_q[widx[3:0]] <= {dhi_q, dlo_q};

   // open drain: only the low level is ever driven
   always_ff @(posedge mclk or negedge resetn)
      if (!resetn)
      begin
         sda_o <= 1'b0;
         scl_o <= 1'b0;
         scl_oe <= 1'b0;
      end
      else
      begin
         sda_o <= 1'b0;
         scl_o <= 1'b0;
         scl_oe <= 1'b0;
      end

   assign sda_oe = sda_oe_q;
   // field outputs are slices of the storage flops, except auto_level_on, an OR of a nibble
   assign adc_gain_left = mem_q[codec_ctrl_pkg::I_CONV][15:12];
   assign adc_gain_right = mem_q[codec_ctrl_pkg::I_CONV][11:8];
   assign mic_gain = mem_q[codec_ctrl_pkg::I_CONV][7:4];
   assign left_src_mic =
      mem_q[codec_ctrl_pkg::I_CONV][codec_ctrl_pkg::F_LSEL];
   assign adc_left_en =
      mem_q[codec_ctrl_pkg::I_CONV][codec_ctrl_pkg::F_EN_L];
   assign adc_right_en =
      mem_q[codec_ctrl_pkg::I_CONV][codec_ctrl_pkg::F_EN_R];
   assign dac_en = mem_q[codec_ctrl_pkg::I_CONV][codec_ctrl_pkg::F_EN_DA];
   // the reference follows the dac bit; host keeps an a/d on meanwhile
   assign analog_reference_en =
      mem_q[codec_ctrl_pkg::I_CONV][codec_ctrl_pkg::F_EN_DA];
   assign input_mono =
      mem_q[codec_ctrl_pkg::I_IN_MODE][codec_ctrl_pkg::F_TOP];
   assign deemph_sel = mem_q[codec_ctrl_pkg::I_IN_MODE][1:0];
   assign dac_src_adc =
      mem_q[codec_ctrl_pkg::I_OUT_SRC][codec_ctrl_pkg::F_TOP];
   assign mix_adc_scale = mem_q[codec_ctrl_pkg::I_MIX_ADC][15:8];
   assign mix_dsp_scale = mem_q[codec_ctrl_pkg::I_MIX_DSP][15:8];
   assign out_mono =
      mem_q[codec_ctrl_pkg::I_OUT_MODE][codec_ctrl_pkg::F_TOP];
   assign out_invert_right =
      mem_q[codec_ctrl_pkg::I_OUT_MODE][codec_ctrl_pkg::F_INV];
   assign low_shelf_gain = mem_q[codec_ctrl_pkg::I_LOW][15:8];
   assign high_shelf_gain = mem_q[codec_ctrl_pkg::I_HIGH][15:8];
   assign contour_gain = mem_q[codec_ctrl_pkg::I_CONTOUR][15:8];
   assign contour_fine = mem_q[codec_ctrl_pkg::I_CONTOUR][7:0];
   assign bass_effect_strength =
      mem_q[codec_ctrl_pkg::I_STRENGTH][15:8];
   assign bass_effect_harmonics =
      mem_q[codec_ctrl_pkg::I_HARM][15:8];
   assign bass_effect_centre = mem_q[codec_ctrl_pkg::I_CENTRE][15:8];
   assign bass_effect_corner = mem_q[codec_ctrl_pkg::I_SHAPE][15:8];
   assign bass_effect_on =
      mem_q[codec_ctrl_pkg::I_SHAPE][codec_ctrl_pkg::F_BASS_ON];
   // any top nibble but zero counts as on
   assign auto_level_on = |mem_q[codec_ctrl_pkg::I_AUTO][15:12];
   assign auto_level_decay = mem_q[codec_ctrl_pkg::I_AUTO][11:8];
   assign left_right_trim = mem_q[codec_ctrl_pkg::I_TRIM][15:8];
   assign main_gain = mem_q[codec_ctrl_pkg::I_MAIN][15:8];

   property p_drive_only_ack_tx;
      @(posedge mclk) disable iff (!resetn)
      sda_oe_q |-> (state_q == st_ack || state_q == st_tx);
   endproperty
   a_drive_only_ack_tx: assert property (p_drive_only_ack_tx)
      else $error("sda driven outside ack or transmit");

   property p_main_write;
      @(posedge mclk) disable iff (!resetn)
      (wr_go && sub_wr_q && widx[3:0] == codec_ctrl_pkg::I_MAIN)
         |=> main_gain == $past(dhi_q);
   endproperty
   a_main_write: assert property (p_main_write)
      else $error("volume byte not stored from high data byte");

   property p_conv_change_cause;
      @(posedge mclk) disable iff (!resetn)
      !$stable(mem_q[codec_ctrl_pkg::I_CONV]) |-> $past(wr_go);
   endproperty
   a_conv_change_cause: assert property (p_conv_change_cause)
      else $error("register changed without completed write");
   property p_level_read;
      @(posedge mclk) disable iff (!resetn)
      (state_q == st_ack && scl_fall && rw_q && byte_q == 3'h0 &&
       ptr_q == codec_ctrl_pkg::A_LVL_INL)
         |=> word_q == {1'b0, $past(input_level_left)};
   endproperty
   a_level_read: assert property (p_level_read)
      else $error("level readout wrong");

   property p_bad_sub;
      @(posedge mclk) disable iff (!resetn)
      (state_q == st_rx && scl_fall && !start_c && !stop_c &&
       nbits_q == codec_ctrl_pkg::BYTE_BITS &&
       byte_q == codec_ctrl_pkg::BY_SUB &&
       sh_q != codec_ctrl_pkg::SUB_WRITE &&
       sh_q != codec_ctrl_pkg::SUB_READ) |=> state_q == st_idle;
   endproperty
   a_bad_sub: assert property (p_bad_sub)
      else $error("unknown subaddress acknowledged");

   property p_first_bit;
      @(posedge mclk) disable iff (!resetn)
      (state_q == st_ack && scl_fall && !start_c && !stop_c && rw_q &&
       byte_q == 3'h0)
         |=> state_q == st_tx && sda_oe_q == ~word_q[15];
   endproperty
   a_first_bit: assert property (p_first_bit)
      else $error("read did not start with high data bit");

   property p_nack_ends;
      @(posedge mclk) disable iff (!resetn)
      (state_q == st_rack && scl_rise && sda_s2 && !start_c && !stop_c)
         |=> state_q == st_idle ##1 !sda_oe_q;
   endproperty
   a_nack_ends: assert property (p_nack_ends)
      else $error("transmit continued after not-acknowledge");

   property p_ptr_load;
      @(posedge mclk) disable iff (!resetn)
      (state_q == st_rx && scl_fall && !start_c && !stop_c && sub_wr_q &&
       nbits_q == codec_ctrl_pkg::BYTE_BITS &&
       byte_q == codec_ctrl_pkg::BY_RLO)
         |=> ptr_q == {rhi_q, $past(sh_q)} && sda_oe_q;
   endproperty
   a_ptr_load: assert property (p_ptr_load)
      else $error("register number not taken");
endmodule
`default_nettype wire

// File: verification/i2c_host_model.sv
// two-wire host master model, driving scl and sda as open-drain sources.
// assumes pull-ups on both lines and mclk well above eight times scl.
`default_nettype none
module i2c_host_model (
   // clock
   input wire logic mclk,
   // line drives and sensed data level
   output logic scl_drv,
   output logic sda_drv,
   input wire logic sda_line
);
   timeunit 1ns;
   timeprecision 1ns;
   // half scl period in mclk cycles; slow enough for the two-flop sync
   localparam int H = 10;
   initial
   begin
      scl_drv = 1'b1;
      sda_drv = 1'b1;
   end
   task automatic hw();
      repeat (H) @(posedge mclk);
   endtask
   task automatic start();
      sda_drv <= 1'b1;
      hw();
      scl_drv <= 1'b1;
      hw();
      sda_drv <= 1'b0;
      hw();
      scl_drv <= 1'b0;
   endtask
   task automatic stop();
      repeat (2) @(posedge mclk);
      sda_drv <= 1'b0;
      hw();
      scl_drv <= 1'b1;
      hw();
      sda_drv <= 1'b1;
      hw();
   endtask
   // data changes two cycles after scl falls, keeping hold time
   task automatic xbit(input logic b, output logic r);
      repeat (2) @(posedge mclk);
      sda_drv <= b;
      hw();
      scl_drv <= 1'b1;
      hw();
      r = sda_line;
      scl_drv <= 1'b0;
   endtask
   task automatic put(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--)
         xbit(b[i], r);
      xbit(1'b1, r);
      ack = ~r;
   endtask
   task automatic get(input logic last, output logic [7:0] b);
      logic r;
      for (int i = 7; i >= 0; i--)
      begin
         xbit(1'b1, r);
         b[i] = r;
      end
      xbit(last, r);
   endtask
endmodule
`default_nettype wire

// File: verification/tb_audio_codec_control_registers.sv
// self-checking bench for the codec control register bank.
// assumes the host model drives the serial lines; levels come from the bench.
`default_nettype none
module tb_audio_codec_control_registers;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [7:0] device_write_addr =
      {codec_ctrl_pkg::DEV_ADDR_BASE | 7'h01, 1'b0};
   localparam logic [15:0] WA [16] = '{16'h0000, 16'h0006, 16'h0007,
      16'h000e, 16'h000f, 16'h0010, 16'h0011, 16'h0012, 16'h0014, 16'h0015,
      16'h001e, 16'h0021, 16'h0022, 16'h0023, 16'h0024, 16'h8000};
   logic mclk = 1'b0;
   logic resetn = 1'b0;
   logic scl_o, scl_oe, sda_o, sda_oe, scl_h, sda_h;
   logic [14:0] lv [4] = '{default: 15'h0000};
   wire [124:0] o;
   logic [15:0] m [65536] = '{default: 16'h0000};
   int fail_count = 0;
   int comparisons = 0;
   wire scl_w = scl_h & ~(scl_oe & ~scl_o);
   wire sda_w = sda_h & ~(sda_oe & ~sda_o);
   always #50 mclk = ~mclk;
   i2c_host_model h (.mclk(mclk), .scl_drv(scl_h), .sda_drv(sda_h),
      .sda_line(sda_w));
   codec_ctrl_regs dut (.mclk(mclk), .resetn(resetn), .scl_i(scl_w),
      .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(sda_o),
      .sda_oe(sda_oe), .addr_select(1'b1), .input_level_left(lv[0]),
      .input_level_right(lv[1]), .processing_level_left(lv[2]),
      .processing_level_right(lv[3]), .adc_gain_left(o[124:121]),
      .adc_gain_right(o[120:117]), .mic_gain(o[116:113]),
      .left_src_mic(o[112]), .adc_left_en(o[111]), .adc_right_en(o[110]),
      .dac_en(o[109]), .analog_reference_en(o[108]), .input_mono(o[107]),
      .deemph_sel(o[106:105]), .dac_src_adc(o[104]),
      .mix_adc_scale(o[103:96]), .mix_dsp_scale(o[95:88]),
      .out_mono(o[87]), .out_invert_right(o[86]), .low_shelf_gain(o[85:78]),
      .high_shelf_gain(o[77:70]), .contour_gain(o[69:62]),
      .contour_fine(o[61:54]), .bass_effect_strength(o[53:46]),
      .bass_effect_harmonics(o[45:38]), .bass_effect_centre(o[37:30]),
      .bass_effect_corner(o[29:22]), .bass_effect_on(o[21]),
      .auto_level_on(o[20]), .auto_level_decay(o[19:16]),
      .left_right_trim(o[15:8]), .main_gain(o[7:0]));
   task automatic give_verdict();
      $display("fail_count=%0d comparisons=%0d", fail_count, comparisons);
      if (fail_count == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic bad(input string s);
      fail_count++;
      $display("[FAIL] %0t %s", $time, s);
   endtask
   task automatic chk_ack(input logic g, input logic e);
      comparisons++;
      if (g !== e) bad("acknowledge");
   endtask
   task automatic chk_word(input logic [15:0] g, input logic [15:0] e);
      comparisons++;
      if (g !== e) bad($sformatf("read %h want %h", g, e));
   endtask
   task automatic chk_outs();
      logic [124:0] e;
      e = {m[0], m[0][0], m['h8000][15], m['h8000][1:0], m['hf][15],
         m['h6][15:8], m['h7][15:8], m['he][15:14], m['h14][15:8],
         m['h15][15:8], m['h1e], m['h22][15:8], m['h23][15:8],
         m['h24][15:8], m['h21][15:8], m['h21][1], |m['h12][15:12],
         m['h12][11:8], m['h11][15:8], m['h10][15:8]};
      comparisons++;
      if (o !== e)
         bad($sformatf("outputs %h want %h", o, e));
      comparisons++;
      if ({scl_o, scl_oe, sda_o} !== 3'h0) bad("line drives");
   endtask
   function automatic logic [15:0] exp_rd(input logic [15:0] a);
      if (a >= 16'h000a && a <= 16'h000d) return {1'b0, lv[a - 16'h000a]};
      return m[a];
   endfunction
   // n bytes of the six are sent; fewer models a transfer cut short
   task automatic wr(input logic [15:0] a, input logic [15:0] d, input int n);
      logic [7:0] b [6];
      logic k;
      b = '{device_write_addr, codec_ctrl_pkg::SUB_WRITE, a[15:8], a[7:0],
         d[15:8], d[7:0]};
      h.start();
      for (int i = 0; i < n; i++)
      begin
         h.put(b[i], k);
         chk_ack(k, 1'b1);
      end
      h.stop();
      foreach (WA[j])
         if (n == 6 && WA[j] == a) m[a] = d;
      repeat (4) @(posedge mclk);
      chk_outs();
   endtask
   task automatic rd(input logic [15:0] a, output logic [15:0] d);
      logic k;
      wr(a, 16'h0000, 4);
      h.start();
      h.put(device_write_addr, k);
      h.put(codec_ctrl_pkg::SUB_READ, k);
      chk_ack(k, 1'b1);
      h.start();
      h.put(device_write_addr | 8'h01, k);
      h.get(1'b0, d[15:8]);
      h.get(1'b1, d[7:0]);
      h.stop();
   endtask
   initial
   begin
      logic [15:0] d, g;
      logic k;
      foreach (WA[i]) m[WA[i]] = 16'h0000;
      d = 16'($urandom(7));
      repeat (5) @(posedge mclk);
      resetn <= 1'b1;
      repeat (4) @(posedge mclk);
      chk_outs();
      foreach (WA[i])
      begin
         d = 16'($urandom());
         // an a/d stays enabled whenever the dac is written, reference follows the random dac bit
         if (WA[i] == 16'h0000) d = d | 16'h0002;
         wr(WA[i], d, 6);
         rd(WA[i], g);
         chk_word(g, exp_rd(WA[i]));
      end
      wr(16'h000e, 16'hc000, 6);
      wr(16'h0010, 16'h7300, 5);
      wr(16'h0003, 16'h1234, 6);
      rd(16'h0003, g);
      chk_word(g, 16'h0000);
      @(posedge mclk);
      foreach (lv[i]) lv[i] <= 15'($urandom());
      foreach (lv[i])
      begin
         rd(16'h000a + 16'(i), g);
         chk_word(g, exp_rd(16'h000a + 16'(i)));
      end
      h.start();
      h.put(device_write_addr, k);
      h.put(8'h55, k);
      chk_ack(k, 1'b0);
      h.stop();
      give_verdict();
   end
   initial
   begin
      #9000000;
      bad("watchdog expired");
      give_verdict();
   end
endmodule
`default_nettype wire
